// [verilog/analog_input_track_hold.sv]
// Eight-channel input result logic with per-channel track and hold
module analog_input_track_hold
	import track_hold_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	// Register port
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	// Raw converter samples, one channel per strobe
	input  wire logic              i_sample_valid,
	input  wire logic [CHAN_W-1:0] i_sample_chan,
	input  wire logic [DATA_W-1:0] i_sample_raw
);
	logic [DATA_W-1:0]   input_hold_select;
	logic [DATA_W-1:0]   input_resolution;
	logic                format_binary;
	logic [NUM_CHAN-1:0] captured;
	logic [NUM_CHAN-1:0] fresh;
	logic [DATA_W-1:0]   result     [NUM_CHAN];
	logic [DATA_W-1:0]   sel_result;
	logic [DATA_W-1:0]   sel_bcd;
	logic [DATA_W-1:0]   next_rdata;
	logic                rd_result;
	logic [CHAN_W-1:0]   rd_chan;
	res_mode_t           in_res;

	sample_if smp ();

	// Software writes to the hold select word, live at any time
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			input_hold_select <= HOLD_SELECT_RESET;
		else if (i_wr && i_addr == ADDR_HOLD_SELECT)
			input_hold_select <= i_wdata;
	end

	// Per-channel resolution codes
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			input_resolution <= RESOLUTION_RESET;
		else if (i_wr && i_addr == ADDR_RESOLUTION)
			input_resolution <= i_wdata;
	end

	// Result coding; one bit covers all channels
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			format_binary <= FORMAT_RESET;
		else if (i_wr && i_addr == ADDR_FORMAT)
			format_binary <= i_wdata[FORMAT_BINARY_BIT];
	end

	// Resolution of the channel whose raw sample arrives now
	assign in_res = res_mode_t'(input_resolution[2*i_sample_chan +: 2]);

	// Scaling takes one cycle; the code used is the one at arrival
	count_scaler u_scaler (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_valid (i_sample_valid),
		.i_chan  (i_sample_chan),
		.i_raw   (i_sample_raw),
		.i_res   (in_res),
		.smp     (smp)
	);

	// One result word, hold state and change tracking per channel
	for (genvar n = 0; n < NUM_CHAN; n++)
	begin : g_chan
		hold_mode_t code;
		res_mode_t  res;
		hold_mode_t prev_code;
		res_mode_t  prev_res;
		logic       hit;
		logic       restart;
		logic       take;
		logic       lower;
		logic       higher;

		// Channel n+1 owns bits 2n+1 (high) and 2n (low)
		assign code = hold_mode_t'(input_hold_select[2*n+1 -: 2]);
		assign res  = res_mode_t'(input_resolution[2*n+1 -: 2]);
		assign hit  = smp.valid && (smp.chan == CHAN_W'(n));

		// A changed code or resolution forgets the old held value
		assign restart = (code != prev_code) || (res != prev_res);
		assign lower   = smp.count < result[n];
		assign higher  = smp.count > result[n];

		// Decide whether this sample replaces the result word
		always_comb
		begin
			unique case (code)
				HOLD_NONE:  take = 1'b1;
				HOLD_MIN:   take = !captured[n] || restart || lower;
				HOLD_MAX:   take = !captured[n] || restart || higher;
				HOLD_RESET: take = 1'b1;
			endcase
		end

		// Codes seen on the last cycle, for change detection
		always_ff @(posedge i_clk or negedge i_nrst)
		begin
			if (!i_nrst)
			begin
				prev_code <= HOLD_NONE;
				prev_res  <= RES_12;
			end
			else
			begin
				prev_code <= code;
				prev_res  <= res;
			end
		end

		// Result word: cleared at reset, zero while the channel is off
		always_ff @(posedge i_clk or negedge i_nrst)
		begin
			if (!i_nrst)
				result[n] <= RESULT_RESET;
			else if (res == RES_OFF)
				result[n] <= RESULT_RESET;
			else if (hit && take)
				result[n] <= smp.count;
		end

		// Held value counts only in min or max mode
		always_ff @(posedge i_clk or negedge i_nrst)
		begin
			if (!i_nrst)
				captured[n] <= 1'b0;
			else if (res == RES_OFF)
				captured[n] <= 1'b0;
			else if (code == HOLD_NONE || code == HOLD_RESET)
				captured[n] <= 1'b0;
			else if (hit)
				captured[n] <= 1'b1;
			else if (restart)
				captured[n] <= 1'b0;
		end

		// New-data flag; a set in the clearing read cycle wins
		always_ff @(posedge i_clk or negedge i_nrst)
		begin
			if (!i_nrst)
				fresh[n] <= 1'b0;
			else if (hit && take && res != RES_OFF)
				fresh[n] <= 1'b1;
			else if (rd_result && rd_chan == CHAN_W'(n))
				fresh[n] <= 1'b0;
		end
	end

	// Decode of the eight result words
	assign rd_result = i_rd &&
		(i_addr >= ADDR_RESULT_BASE) &&
		(i_addr < ADDR_RESULT_BASE + ADDR_W'(NUM_CHAN));
	assign rd_chan   = CHAN_W'(i_addr - ADDR_RESULT_BASE);
	assign sel_result = result[rd_chan];

	// BCD view of the word being read
	bcd_encoder u_bcd (
		.i_bin (sel_result),
		.o_bcd (sel_bcd)
	);

	// Read mux; unmapped words read as zero
	always_comb
	begin
		next_rdata = '0;
		if (rd_result)
			next_rdata = format_binary ? sel_result : sel_bcd;
		else if (i_addr == ADDR_HOLD_SELECT)
			next_rdata = input_hold_select;
		else if (i_addr == ADDR_RESOLUTION)
			next_rdata = input_resolution;
		else if (i_addr == ADDR_FORMAT)
			next_rdata = DATA_W'(format_binary);
		else if (i_addr == ADDR_CAPTURED)
			next_rdata = DATA_W'(captured);
		else if (i_addr == ADDR_FRESH)
			next_rdata = DATA_W'(fresh);
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_rdata <= '0;
		else if (i_rd)
			o_rdata <= next_rdata;
		else
			o_rdata <= '0;
	end
endmodule

// [inc/track_hold_pkg.sv]
// Constants, register map and mode types for the track-and-hold input block
package track_hold_pkg;

	// Channel count and word widths
	localparam int NUM_CHAN = 8;
	localparam int CHAN_W   = 3;
	localparam int DATA_W   = 16;
	localparam int ADDR_W   = 8;

	// Register word addresses
	localparam logic [ADDR_W-1:0] ADDR_HOLD_SELECT = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESOLUTION  = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_FORMAT      = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURED    = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_FRESH       = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_RESULT_BASE = 8'h10;

	// Values after reset
	localparam logic [DATA_W-1:0] HOLD_SELECT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] RESOLUTION_RESET  = 16'h0000;
	localparam logic              FORMAT_RESET      = 1'b1;
	localparam logic [DATA_W-1:0] RESULT_RESET      = 16'h0000;

	// Field position of the binary/BCD select in the format word
	localparam int FORMAT_BINARY_BIT = 0;

	// Largest count of each resolution, and of the raw converter code
	localparam logic [DATA_W-1:0] MAX_COUNT_12  = 16'h0FFF;
	localparam logic [DATA_W-1:0] MAX_COUNT_14  = 16'h3FFF;
	localparam logic [DATA_W-1:0] MAX_COUNT_16  = 16'hFFFF;
	localparam logic [DATA_W-1:0] RAW_FULL_SCALE = 16'hFFFF;

	// Largest value one BCD word can show
	localparam logic [DATA_W-1:0] BCD_MAX = 16'h270F;

	// Per-channel hold codes, in code order 00, 01, 10, 11
	typedef enum logic [1:0] {
		HOLD_NONE,
		HOLD_MIN,
		HOLD_MAX,
		HOLD_RESET
	} hold_mode_t;

	// Per-channel resolution codes, in code order 00, 01, 10, 11
	typedef enum logic [1:0] {
		RES_12,
		RES_14,
		RES_16,
		RES_OFF
	} res_mode_t;

endpackage

// [inc/sample_if.sv]
// Scaled sample stream from the count scaler to the hold logic
interface sample_if
	import track_hold_pkg::*;
();
	logic              valid;
	logic [CHAN_W-1:0] chan;
	logic [DATA_W-1:0] count;

	modport src (output valid, output chan, output count);
	modport dst (input valid, input chan, input count);
endinterface

// [verilog/count_scaler.sv]
// Maps a raw full-span converter code onto the 12, 14 or 16 bit count range
module count_scaler
	import track_hold_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	// Raw sample in
	input  wire logic              i_valid,
	input  wire logic [CHAN_W-1:0] i_chan,
	input  wire logic [DATA_W-1:0] i_raw,
	input  wire res_mode_t         i_res,
	// Scaled sample out
	sample_if.src                  smp
);
	logic [DATA_W-1:0] max_count;
	logic [31:0]       product;
	logic [32:0]       quotient_sum;
	logic [DATA_W-1:0] next_count;

	// Largest count of the selected resolution
	always_comb
	begin
		unique case (i_res)
			RES_12:  max_count = MAX_COUNT_12;
			RES_14:  max_count = MAX_COUNT_14;
			RES_16:  max_count = MAX_COUNT_16;
			RES_OFF: max_count = 16'h0000;
		endcase
	end

	// Level times largest count over full scale; no live-zero offset
	// Divide by 65535 done as (p + p/65536 + 1)/65536, exact for any product of two 16-bit values
	assign product      = 32'(i_raw) * 32'(max_count);
	assign quotient_sum = 33'(product) + 33'(product >> 16) + 33'h000000001;
	assign next_count   = quotient_sum[31:16];

	// Full scale itself must land on the top count, unrounded
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			smp.valid <= 1'b0;
			smp.chan  <= '0;
			smp.count <= '0;
		end
		else
		begin
			smp.valid <= i_valid;
			smp.chan  <= i_chan;
			smp.count <= (i_raw == RAW_FULL_SCALE) ? max_count : next_count;
		end
	end
endmodule

// [verilog/bcd_encoder.sv]
// Binary to four-digit BCD converter for one result word
module bcd_encoder
	import track_hold_pkg::*;
(
	// Binary value in
	input  wire logic [DATA_W-1:0] i_bin,
	// BCD value out
	output logic      [DATA_W-1:0] o_bcd
);
	logic [DATA_W-1:0] clipped;

	// Values past four digits cannot be shown, so they clip at 9999
	assign clipped = (i_bin > BCD_MAX) ? BCD_MAX : i_bin;

	// Shift-and-add-three conversion
	always_comb
	begin
		logic [31:0] work;
		work = 32'(clipped);
		for (int i = 0; i < DATA_W; i++)
		begin
			for (int d = 0; d < 4; d++)
			begin
				if (work[16+4*d +: 4] > 4'h4)
					work[16+4*d +: 4] = work[16+4*d +: 4] + 4'h3;
			end
			work = work << 1;
		end
		o_bcd = work[31:16];
	end
endmodule

// [tb/track_hold_asserts.sv]
// Register port checker for the track-and-hold block
module track_hold_asserts
	import track_hold_pkg::*;
(
	// Clock and reset
	input wire logic              i_clk,
	input wire logic              i_nrst,
	// Register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [DATA_W-1:0] o_rdata
);
	logic [DATA_W-1:0] hold_copy;
	logic [DATA_W-1:0] res_copy;
	logic [DATA_W-1:0] res_prev;
	logic              fmt_copy;
	logic [1:0]        res_cur;
	logic [1:0]        res_was;
	logic              rd_res;

	// Shadow of the writable words, so reads can be judged
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			hold_copy <= HOLD_SELECT_RESET;
			res_copy  <= RESOLUTION_RESET;
			fmt_copy  <= FORMAT_RESET;
		end
		else if (i_wr)
		begin
			if (i_addr == ADDR_HOLD_SELECT)
				hold_copy <= i_wdata;
			if (i_addr == ADDR_RESOLUTION)
				res_copy <= i_wdata;
			if (i_addr == ADDR_FORMAT)
				fmt_copy <= i_wdata[FORMAT_BINARY_BIT];
		end
	end

	// Resolution one cycle back; a result is zeroed an edge after turn-off
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			res_prev <= RESOLUTION_RESET;
		else
			res_prev <= res_copy;
	end

	// Result word read and the addressed channel's resolution
	assign rd_res  = i_rd && (i_addr[7:3] == 5'h02);
	assign res_cur = res_copy[{i_addr[2:0], 1'b0} +: 2];
	assign res_was = res_prev[{i_addr[2:0], 1'b0} +: 2];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	property p_idle; !i_rd |=> o_rdata == '0; endproperty
	a_idle: assert property (p_idle)
		else $error("read data not zero outside a read");
	property p_hold; i_rd && i_addr == ADDR_HOLD_SELECT
		|=> o_rdata == hold_copy; endproperty
	a_hold: assert property (p_hold)
		else $error("hold select read back wrong");
	property p_res; i_rd && i_addr == ADDR_RESOLUTION
		|=> o_rdata == res_copy; endproperty
	a_res: assert property (p_res)
		else $error("resolution read back wrong");
	property p_fmt; i_rd && i_addr == ADDR_FORMAT
		|=> o_rdata == DATA_W'(fmt_copy); endproperty
	a_fmt: assert property (p_fmt)
		else $error("format read back wrong");
	property p_unmapped; i_rd && (i_addr > 8'h17 ||
		(i_addr > 8'h04 && i_addr < 8'h10)) |=> o_rdata == '0; endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_flags; i_rd && (i_addr == ADDR_CAPTURED ||
		i_addr == ADDR_FRESH) |=> o_rdata[15:8] == 8'h00; endproperty
	a_flags: assert property (p_flags)
		else $error("flag word upper byte not zero");
	property p_off; rd_res && res_cur == RES_OFF && res_was == RES_OFF
		|=> o_rdata == '0; endproperty
	a_off: assert property (p_off)
		else $error("disabled channel result not zero");
	property p_bcd; rd_res && !fmt_copy |=> o_rdata[15:12] < 4'hA &&
		o_rdata[11:8] < 4'hA && o_rdata[7:4] < 4'hA &&
		o_rdata[3:0] < 4'hA; endproperty
	a_bcd: assert property (p_bcd)
		else $error("result in decimal mode has a bad digit");
endmodule

bind analog_input_track_hold track_hold_asserts chk_i (.i_clk, .i_nrst,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);

// [tb/sample_source.sv]
// Converter model feeding raw full-span samples to the block
module sample_source
	import track_hold_pkg::*;
(
	// Clock
	input  wire logic              i_clk,
	// Raw sample out
	output logic                   o_valid,
	output logic      [CHAN_W-1:0] o_chan,
	output logic      [DATA_W-1:0] o_raw
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle lines at time zero
	initial
	begin
		o_valid = 1'b0;
		o_chan  = '0;
		o_raw   = '0;
	end

	// One strobe; stale data is inverted so it never looks valid
	task automatic send(input logic [CHAN_W-1:0] c,
		input logic [DATA_W-1:0] r);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_chan  <= c;
		o_raw   <= r;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_chan  <= ~c;
		o_raw   <= ~r;
	endtask
endmodule

// [tb/analog_input_track_hold_test.sv]
// Register and sample tests for the track-and-hold block
module analog_input_track_hold_test
	import track_hold_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              i_clk   = 1'b0;
	logic              i_nrst  = 1'b0;
	logic              i_wr    = 1'b0;
	logic              i_rd    = 1'b0;
	logic [ADDR_W-1:0] i_addr  = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic [DATA_W-1:0] o_rdata;
	logic              smp_valid;
	logic [CHAN_W-1:0] smp_chan;
	logic [DATA_W-1:0] smp_raw;
	int                mismatches = 0;
	int                num_checks = 0;

	// 40 MHz clock
	always #12.5 i_clk = ~i_clk;

	analog_input_track_hold dut (.i_clk, .i_nrst, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_sample_valid(smp_valid),
		.i_sample_chan(smp_chan), .i_sample_raw(smp_raw));
	sample_source src (.i_clk, .o_valid(smp_valid), .o_chan(smp_chan),
		.o_raw(smp_raw));

	// One-cycle write strobe
	task automatic wr(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Read strobe, data looked at in the following cycle only
	task automatic chk(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] e);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		num_checks++;
		if (o_rdata !== e)
		begin
			mismatches++;
			$display("[ERR] word %h expected %h seen %h", a, e, o_rdata);
		end
	endtask

	// Sample, wait out the two-edge latency, read the result
	task automatic scale(input logic [CHAN_W-1:0] c,
		input logic [DATA_W-1:0] r, e);
		src.send(c, r);
		repeat (2) @(posedge i_clk);
		chk(ADDR_RESULT_BASE + ADDR_W'(c), e);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog, far beyond the under two hundred cycles the tests need
	initial
	begin
		#50us;
		mismatches++;
		finish_test();
	end

	// Test sequence
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_nrst <= 1'b1;
		chk(ADDR_HOLD_SELECT, HOLD_SELECT_RESET);
		chk(ADDR_FORMAT, 16'h0001);
		chk(ADDR_CAPTURED, 16'h0000);
		chk(ADDR_RESULT_BASE, RESULT_RESET);
		chk(8'h20, 16'h0000);
		$display("test reset done");
		// Ch1 12 bit, ch2 14 bit, ch8 off, others 16 bit
		wr(ADDR_RESOLUTION, 16'hEAA4);
		chk(ADDR_RESOLUTION, 16'hEAA4);
		scale(0, 16'hFFFF, MAX_COUNT_12);
		scale(0, 16'h9999, 16'h0999);
		scale(1, 16'hFFFF, MAX_COUNT_14);
		scale(2, 16'h9999, 16'h9999);
		scale(2, 16'h3333, 16'h3333);
		scale(7, 16'hFFFF, 16'h0000);
		$display("test scaling done");
		// Ch4 minimum, ch5 maximum, ch6 live, set while running
		wr(ADDR_HOLD_SELECT, 16'h0240);
		scale(3, 16'hFFFF, 16'hFFFF);
		scale(3, 16'h5000, 16'h5000);
		scale(3, 16'h6000, 16'h5000);
		scale(4, 16'h0000, 16'h0000);
		scale(4, 16'h0800, 16'h0800);
		scale(4, 16'h0400, 16'h0800);
		chk(ADDR_CAPTURED, 16'h0018);
		scale(5, 16'h7000, 16'h7000);
		scale(5, 16'h1000, 16'h1000);
		$display("test hold done");
		// Ch4 to reset code, then back to minimum
		wr(ADDR_HOLD_SELECT, 16'h02C0);
		scale(3, 16'h7000, 16'h7000);
		scale(3, 16'h6800, 16'h6800);
		wr(ADDR_HOLD_SELECT, 16'h0240);
		scale(3, 16'h8000, 16'h8000);
		scale(3, 16'h9000, 16'h8000);
		$display("test restart done");
		// Decimal coding for all channels, read back on the 12 bit channel
		wr(ADDR_FORMAT, 16'h0000);
		scale(0, 16'hFFFF, 16'h4095);
		wr(ADDR_FORMAT, 16'h0001);
		chk(ADDR_RESULT_BASE, MAX_COUNT_12);
		$display("test coding done");
		// New-data flag set by a sample, cleared by reading that word
		src.send(2, 16'h1234);
		repeat (2) @(posedge i_clk);
		chk(ADDR_FRESH, 16'h0004);
		chk(ADDR_RESULT_BASE + 8'h02, 16'h1234);
		chk(ADDR_FRESH, 16'h0000);
		$display("test fresh done");
		finish_test();
	end
endmodule
